/* ric_bank.sv */
// Purpose: read-only serial number and factory calibration bank with rom check
// Assumes: rom_image comes from the fuse array on the same clock and is stable
// Notes:   the image is captured after reset and on each recheck command given while no check runs;
//          bank reads return the captured factory contents, except bit zero of the lowest serial word, which reads as one
//
// Decided for this implementation: register access over AXI4-Lite.
`timescale 1ns/1ps

// Function
// R1 - bit zero of the lowest serial word always reads as one
// R2 - 40-bit serial split low 16, middle 16, top 8 over three registers
// R3 - software accepts a serial only when at least two bits are set
// R4 - third serial register holds calibration byte high, serial top byte low
// R5 - all bank registers are read-only and return factory rom contents
// R6 - bank contents are covered by the rom check against the stored byte
// R7 - alternate reference register: two cal bits high, 14-bit trim low
// R8 - 8-bit crc with generator 0xa6, stored byte in upper half of later word
// R9 - writes to bank registers change nothing and have no side effect
module ric_bank
(
	input  wire logic                   clk,
	input  wire logic                   rstn,
	input  wire ric_pkg::ric_rom_s      rom_image,
	input  wire ric_pkg::ric_axi_req_s  axi_req,
	output ric_pkg::ric_axi_rsp_s       axi_rsp,
	output logic                        check_busy,
	output logic                        check_bad
);
	import ric_pkg::*;

	typedef enum logic [1:0]
	{
		ST_LOAD  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_IDLE  = 2'b10
	} ric_state_e;

	ric_state_e state;
	ric_state_e next_state;

	ric_rom_s          shadow;
	logic [7:0]        bit_left;
	logic [CRC_BITS-1:0] stream;
	logic              crc_clear;
	logic              crc_shift;
	logic              crc_din;
	logic [7:0]        crc_value;
	logic              check_done;
	logic              recheck_req;

	logic                wr_fire;
	logic [ADDR_W-1:0]   wr_addr;
	logic [DATA_W-1:0]   wr_data;
	logic                wr_err;
	logic                rd_fire;
	logic [ADDR_W-1:0]   rd_addr;
	logic [DATA_W-1:0]   rd_data;
	logic                rd_err;

	// word index from a byte address; the two low bits select no lane
	function automatic logic [IDX_W-1:0] word_index(input logic [ADDR_W-1:0] addr);
		word_index = addr[ADDR_W-1:2];
	endfunction

	// true for every index that answers with okay
	function automatic logic is_mapped(input logic [IDX_W-1:0] idx);
		unique case (idx)
			IDX_SERIAL_LOW, IDX_SERIAL_MID, IDX_SERIAL_TOP, IDX_CAL_THREE,
			IDX_CAL_ALT_REF, IDX_CAL_FIVE, IDX_CAL_SIX, IDX_ROM_CHECK,
			IDX_CHECK_CTRL, IDX_CHECK_STATUS:
				is_mapped = 1'b1;
			default:
				is_mapped = 1'b0;
		endcase
	endfunction

	ric_axil u_axil
	(
		.clk     (clk),
		.rstn    (rstn),
		.axi_req (axi_req),
		.axi_rsp (axi_rsp),
		.wr_fire (wr_fire),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_err  (wr_err),
		.rd_fire (rd_fire),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_err  (rd_err)
	);

	ric_crc8 u_crc
	(
		.clk   (clk),
		.rstn  (rstn),
		.clear (crc_clear),
		.shift (crc_shift),
		.din   (crc_din),
		.crc   (crc_value)
	);

	assign wr_err = !is_mapped(word_index(wr_addr));
	assign rd_err = !is_mapped(word_index(rd_addr));

	// only the control word reacts to a write; bank words have no write path
	assign recheck_req = wr_fire
		&& (word_index(wr_addr) == IDX_CHECK_CTRL)
		&& wr_data[CTRL_RECHECK_BIT]; // R9

	// sequencer: capture image, then run the check over it
	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_LOAD:
				next_state = ST_SHIFT;
			ST_SHIFT:
				if (bit_left == {1'b0, CRC_LAST})
					next_state = ST_IDLE;
			ST_IDLE:
				if (recheck_req)
					next_state = ST_LOAD;
			default:
				next_state = ST_LOAD;
		endcase
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			state <= ST_LOAD;
		else
			state <= next_state;
	end

	// a fresh image is taken only between checks, so reads never see a half update
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			shadow <= '0;
		else if (state == ST_LOAD)
			shadow <= rom_image; // R5
	end

	// message order: lowest serial word first, msb first, then the byte beside the check
	always_comb
	begin
		stream = '0;
		for (int i = 0; i < ROM_WORDS; i++)
			stream[CRC_BITS-1-16*i -: 16] = shadow.words[i];
		stream[7:0] = shadow.cal_byte_twelve;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			bit_left <= 8'h00;
		else if (state == ST_LOAD)
			bit_left <= 8'(CRC_BITS - 1);
		else if (state == ST_SHIFT && bit_left != 8'h00)
			bit_left <= bit_left - 8'h01;
	end

	assign crc_clear = (state == ST_LOAD);
	assign crc_shift = (state == ST_SHIFT);
	assign crc_din   = stream[bit_left[6:0]]; // R8

	// one crc step, used to fold in the final bit before it reaches the register
	function automatic logic [7:0] next_crc(input logic [7:0] c, input logic d);
		next_crc = {c[6:0], 1'b0} ^ ((c[7] ^ d) ? CRC_POLY : 8'h00);
	endfunction

	// done and bad describe the last finished check; restart clears them
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			check_done <= 1'b0;
			check_bad  <= 1'b0;
		end
		else if (state == ST_LOAD)
		begin
			check_done <= 1'b0;
			check_bad  <= 1'b0;
		end
		else if (state == ST_SHIFT && next_state == ST_IDLE)
		begin
			check_done <= 1'b1;
			// the last bit shifts in on this edge, so compare the stepped value
			check_bad  <= (next_crc(crc_value, crc_din) != shadow.check_byte); // R6
		end
	end

	assign check_busy = (state != ST_IDLE);

	// read decode; upper 16 bits of bank words read as zero
	always_comb
	begin
		rd_data = '0;
		unique case (word_index(rd_addr))
			IDX_SERIAL_LOW:
			begin
				rd_data[15:0]           = shadow.words[0]; // R2
				rd_data[SER_FORCED_BIT] = 1'b1; // R1
			end
			IDX_SERIAL_MID:
				rd_data[15:0] = shadow.words[1]; // R2
			IDX_SERIAL_TOP:
			begin
				rd_data[SER_TOP_LSB +: 8] = shadow.words[2][7:0]; // R4
				rd_data[CAL_TOP_LSB +: 8] = shadow.words[2][15:8]; // R4
			end
			IDX_CAL_THREE:
				rd_data[15:0] = shadow.words[3]; // R5
			IDX_CAL_ALT_REF:
			begin
				rd_data[ALT_TRIM_W-1:0]    = shadow.words[4][ALT_TRIM_W-1:0]; // R7
				rd_data[CAL_FOUR_LSB +: 2] = shadow.words[4][15:14]; // R7
			end
			IDX_CAL_FIVE:
				rd_data[15:0] = shadow.words[5]; // R5
			IDX_CAL_SIX:
				rd_data[15:0] = shadow.words[6]; // R5
			IDX_ROM_CHECK:
			begin
				rd_data[7:0]                = shadow.cal_byte_twelve;
				rd_data[CHECK_BYTE_LSB +: 8] = shadow.check_byte; // R8
			end
			IDX_CHECK_CTRL:
				rd_data = '0;
			IDX_CHECK_STATUS:
			begin
				rd_data[STAT_BUSY_BIT]     = check_busy;
				rd_data[STAT_DONE_BIT]     = check_done;
				rd_data[STAT_BAD_BIT]      = check_bad;
				rd_data[STAT_CRC_LSB +: 8] = crc_value;
			end
			default:
				rd_data = '0;
		endcase
	end

endmodule // ric_bank

/* ric_pkg.sv */
// Purpose: shared constants and carriers for the rom identity and calibration bank
// Assumes: 32-bit axi4-lite register access, one register per aligned word
// Notes:   register offsets are word indices; byte address is four times the index
package ric_pkg;

	// bus geometry
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int IDX_W  = 10;

	// register indices
	localparam logic [IDX_W-1:0] IDX_SERIAL_LOW   = 10'h08c;
	localparam logic [IDX_W-1:0] IDX_SERIAL_MID   = 10'h08d;
	localparam logic [IDX_W-1:0] IDX_SERIAL_TOP   = 10'h08e;
	localparam logic [IDX_W-1:0] IDX_CAL_THREE    = 10'h08f;
	localparam logic [IDX_W-1:0] IDX_CAL_ALT_REF  = 10'h090;
	localparam logic [IDX_W-1:0] IDX_CAL_FIVE     = 10'h091;
	localparam logic [IDX_W-1:0] IDX_CAL_SIX      = 10'h092;
	localparam logic [IDX_W-1:0] IDX_ROM_CHECK    = 10'h098;
	localparam logic [IDX_W-1:0] IDX_CHECK_CTRL   = 10'h0a0;
	localparam logic [IDX_W-1:0] IDX_CHECK_STATUS = 10'h0a1;

	// field positions
	localparam int SER_FORCED_BIT   = 0;
	localparam int SER_TOP_LSB      = 0;
	localparam int CAL_TOP_LSB      = 8;
	localparam int ALT_TRIM_W       = 14;
	localparam int CAL_FOUR_LSB     = 14;
	localparam int CHECK_BYTE_LSB   = 8;
	localparam int CTRL_RECHECK_BIT = 0;
	localparam int STAT_BUSY_BIT    = 0;
	localparam int STAT_DONE_BIT    = 1;
	localparam int STAT_BAD_BIT     = 2;
	localparam int STAT_CRC_LSB     = 8;

	// check code
	localparam logic [7:0] CRC_POLY   = 8'ha6;
	localparam logic [7:0] CRC_INIT   = 8'h00;
	localparam int         ROM_WORDS  = 7;
	localparam int         CRC_BITS   = ROM_WORDS * 16 + 8;
	localparam logic [6:0] CRC_LAST   = 7'h00;

	// reset values
	localparam logic [15:0] WORD_RESET = 16'h0000;
	localparam logic [7:0]  BYTE_RESET = 8'h00;

	// responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// factory rom output, word 0 is the lowest serial word
	typedef struct packed {
		logic [7:0]                 check_byte;
		logic [7:0]                 cal_byte_twelve;
		logic [ROM_WORDS-1:0][15:0] words;
	} ric_rom_s;

	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [DATA_W-1:0] wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} ric_axi_req_s;

	typedef struct packed {
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [DATA_W-1:0] rdata;
		logic [1:0]        rresp;
	} ric_axi_rsp_s;

endpackage

/* ric_crc8.sv */
// Purpose: bit-serial 8-bit crc, msb first
// Assumes: one message bit per enabled cycle
// Notes:   clear takes priority over shift
`timescale 1ns/1ps
module ric_crc8
(
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic       clear,
	input  wire logic       shift,
	input  wire logic       din,
	output logic      [7:0] crc
);
	import ric_pkg::*;

	logic feedback;

	assign feedback = crc[7] ^ din;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			crc <= CRC_INIT;
		else if (clear)
			crc <= CRC_INIT;
		else if (shift)
			crc <= {crc[6:0], 1'b0} ^ (feedback ? CRC_POLY : 8'h00);
	end

endmodule // ric_crc8

/* ric_axil.sv */
// Purpose: axi4-lite slave front end, one write and one read at a time
// Assumes: address and data phases of a write may arrive in either order
// Notes:   read data is taken from the decode in the cycle the address is accepted
`timescale 1ns/1ps
module ric_axil
(
	input  wire logic                        clk,
	input  wire logic                        rstn,
	input  wire ric_pkg::ric_axi_req_s       axi_req,
	output ric_pkg::ric_axi_rsp_s            axi_rsp,
	output logic                             wr_fire,
	output logic      [ric_pkg::ADDR_W-1:0]  wr_addr,
	output logic      [ric_pkg::DATA_W-1:0]  wr_data,
	input  wire logic                        wr_err,
	output logic                             rd_fire,
	output logic      [ric_pkg::ADDR_W-1:0]  rd_addr,
	input  wire logic [ric_pkg::DATA_W-1:0]  rd_data,
	input  wire logic                        rd_err
);
	import ric_pkg::*;

	logic aw_held;
	logic w_held;
	logic bvalid;
	logic rvalid;
	logic [1:0] bresp;
	logic [1:0] rresp;
	logic [DATA_W-1:0] rdata;

	assign wr_fire = aw_held && w_held && !bvalid;
	assign rd_fire = axi_req.arvalid && !rvalid;
	assign rd_addr = axi_req.araddr;

	always_comb
	begin
		axi_rsp         = '0;
		axi_rsp.awready = !aw_held;
		axi_rsp.wready  = !w_held;
		axi_rsp.bvalid  = bvalid;
		axi_rsp.bresp   = bresp;
		axi_rsp.arready = !rvalid;
		axi_rsp.rvalid  = rvalid;
		axi_rsp.rdata   = rdata;
		axi_rsp.rresp   = rresp;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
		end
		else
		begin
			if (axi_req.awvalid && !aw_held)
			begin
				aw_held <= 1'b1;
				wr_addr <= axi_req.awaddr;
			end
			else if (wr_fire)
				aw_held <= 1'b0;
			if (axi_req.wvalid && !w_held)
			begin
				w_held  <= 1'b1;
				wr_data <= axi_req.wdata;
			end
			else if (wr_fire)
				w_held <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid <= 1'b1;
			bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
		end
		else if (axi_req.bready)
			bvalid <= 1'b0;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rvalid <= 1'b0;
			rdata  <= '0;
			rresp  <= RESP_OKAY;
		end
		else if (rd_fire)
		begin
			rvalid <= 1'b1;
			rdata  <= rd_data;
			rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end
		else if (axi_req.rready)
			rvalid <= 1'b0;
	end

endmodule // ric_axil

/* ric_bank_props.sv */
// Purpose: port-level checks of the identity and calibration bank
// Assumes: rom_image only changes while no read is under way
// Notes:   reads are judged outside a check run, when the shadow is settled
`timescale 1ns/1ps
module ric_bank_props
(
	input wire logic                 clk,
	input wire logic                 rstn,
	input wire ric_pkg::ric_rom_s     rom_image,
	input wire ric_pkg::ric_axi_req_s axi_req,
	input wire ric_pkg::ric_axi_rsp_s axi_rsp,
	input wire logic                 check_busy,
	input wire logic                 check_bad
);
	import ric_pkg::*;
	logic        ar;
	logic [9:0]  ix;
	logic [15:0] rd;
	assign ar = axi_req.arvalid && axi_rsp.arready && !check_busy;
	assign ix = axi_req.araddr[11:2];
	assign rd = axi_rsp.rdata[15:0];
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rstn);
	ser_low_a: assert property (
		ar && ix == IDX_SERIAL_LOW |=> rd == {rom_image.words[0][15:1], 1'b1})
		else $error("serial low word wrong");
	ser_mid_a: assert property (
		ar && ix == IDX_SERIAL_MID |=> rd == rom_image.words[1])
		else $error("serial mid word wrong");
	ser_top_a: assert property (
		ar && ix == IDX_SERIAL_TOP |=> rd == rom_image.words[2])
		else $error("serial top word wrong");
	alt_ref_a: assert property (
		ar && ix == IDX_CAL_ALT_REF |=> rd == rom_image.words[4])
		else $error("alternate reference word wrong");
	check_byte_a: assert property (
		ar && ix == IDX_ROM_CHECK |=> rd == {rom_image.check_byte, rom_image.cal_byte_twelve})
		else $error("check byte word wrong");
	read_answer_a: assert property (ar |=> axi_rsp.rvalid)
		else $error("read not answered in one cycle");
	upper_zero_a: assert property (axi_rsp.rvalid |-> axi_rsp.rdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	unmapped_err_a: assert property (
		ar && ix == 10'h093 |=> axi_rsp.rresp == RESP_SLVERR && axi_rsp.rdata == 32'h0)
		else $error("unmapped read not refused");
	bad_at_end_a: assert property (
		$changed(check_bad) |-> check_busy || $past(check_busy))
		else $error("check flag moved outside a check run");
endmodule // ric_bank_props

/* ric_bank_test.sv */
// Purpose: self-checking bench for ric_bank
// Assumes: model of the bank built from the register map
// Notes:   word 0 bit 0 is kept zero in the image so the forced one shows
`timescale 1ns/1ps
module ric_bank_test;
	import ric_pkg::*;
	logic         clk;
	logic         rstn;
	ric_rom_s     rom;
	ric_axi_req_s req;
	ric_axi_rsp_s rsp;
	logic         busy;
	logic         bad;
	int           n_fail;
	int           n_tests;
	int           seed;
	int           t;
	logic [31:0]  d;
	logic [1:0]   r;
	logic [9:0]   ix;
	logic [33:0]  e;
	logic [47:0]  sn;

	ric_bank ric_bank_inst (.clk(clk), .rstn(rstn), .rom_image(rom), .axi_req(req),
		.axi_rsp(rsp), .check_busy(busy), .check_bad(bad));

	task chk(input logic [31:0] s, input logic [31:0] x);
		n_tests++;
		if (s !== x)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, s, x);
		end
	endtask

	task results;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	function automatic logic [7:0] crc_of(input ric_rom_s m);
		logic [7:0]  c;
		logic [15:0] v;
		c = CRC_INIT;
		for (int w = 0; w < 8; w++)
		begin
			v = (w < 7) ? m.words[w] : {m.cal_byte_twelve, 8'h00};
			for (int i = 15; i >= ((w < 7) ? 0 : 8); i--)
				c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	function automatic logic [33:0] exp_of(input logic [9:0] x);
		logic [7:0] c;
		c = crc_of(rom);
		if (x == IDX_SERIAL_LOW)
			return {RESP_OKAY, 16'h0, rom.words[0][15:1], 1'b1};
		if (x > IDX_SERIAL_LOW && x <= IDX_CAL_SIX)
			return {RESP_OKAY, 16'h0, rom.words[x - IDX_SERIAL_LOW]};
		if (x == IDX_ROM_CHECK)
			return {RESP_OKAY, 16'h0, rom.check_byte, rom.cal_byte_twelve};
		if (x == IDX_CHECK_STATUS)
			return {RESP_OKAY, 16'h0, c, 5'h0, rom.check_byte != c, 2'b10};
		return {RESP_SLVERR, 32'h0};
	endfunction

	task fill(input bit good);
		@(posedge clk);
		for (int i = 0; i < ROM_WORDS; i++)
			rom.words[i] <= 16'($random(seed));
		rom.cal_byte_twelve <= 8'($random(seed));
		@(posedge clk);
		rom.words[0][0] <= 1'b0;
		@(posedge clk);
		rom.check_byte <= crc_of(rom) ^ {7'h0, !good};
	endtask

	task rd(input logic [9:0] x);
		@(posedge clk);
		req.arvalid <= 1'b1;
		req.araddr <= {x, 2'b00};
		req.rready <= 1'b1;
		do @(negedge clk); while (rsp.arready !== 1'b1);
		@(posedge clk);
		req.arvalid <= 1'b0;
		do @(negedge clk); while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		@(posedge clk);
		req.rready <= 1'b0;
	endtask

	task wr(input logic [9:0] x, input logic [31:0] v);
		bit pa;
		bit pw;
		bit ta;
		bit tw;
		@(posedge clk);
		req.awvalid <= 1'b1;
		req.awaddr <= {x, 2'b00};
		req.wvalid <= 1'b1;
		req.wdata <= v;
		req.wstrb <= 4'($random(seed));
		req.bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		while (pa || pw)
		begin
			@(negedge clk);
			ta = rsp.awready === 1'b1;
			tw = rsp.wready === 1'b1;
			@(posedge clk);
			if (ta)
				pa = 1'b0;
			if (tw)
				pw = 1'b0;
			req.awvalid <= pa;
			req.wvalid <= pw;
		end
		do @(negedge clk); while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		@(posedge clk);
		req.bready <= 1'b0;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// long enough for four check runs with all their bus traffic
	initial
	begin
		#100000;
		n_fail++;
		results;
	end

	initial
	begin
		seed = 19;
		n_fail = 0;
		n_tests = 0;
		rstn = 1'b0;
		req = '0;
		rom = '0;
		fill(1'b1);
		repeat (17) @(posedge clk);
		chk({31'h0, busy}, 32'h1);
		rstn <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			if (k > 0)
			begin
				fill(!k[0]);
				wr(IDX_CHECK_CTRL, 32'h1);
			end
			t = 0;
			while (busy !== 1'b0 && t < 300)
			begin
				@(negedge clk);
				t++;
			end
			chk({31'h0, busy}, 32'h0);
			chk({31'h0, bad}, {31'h0, k[0]});
			sn = '0;
			for (int i = 'h8c; i <= 'h98; i++)
				if (i < 'h93 || i == 'h98)
				begin
					wr(10'(i), $random(seed));
					chk({30'h0, r}, {30'h0, RESP_OKAY});
				end
			chk({31'h0, busy}, 32'h0);
			for (int i = 'h8b; i <= 'h9a; i++)
			begin
				ix = (i == 'h9a) ? IDX_CHECK_STATUS : 10'(i);
				rd(ix);
				e = exp_of(ix);
				chk({30'h0, r}, {30'h0, e[33:32]});
				chk(d, e[31:0]);
				if (ix >= IDX_SERIAL_LOW && ix <= IDX_SERIAL_TOP)
					sn[16*(ix-IDX_SERIAL_LOW) +: 16] = d[15:0];
			end
			// software side: a serial with fewer than two ones is not a usable identifier
			chk({31'h0, $countones(sn[39:0]) >= 2}, 32'h1);
			$display("run %0d done", k);
		end
		results;
	end
endmodule // ric_bank_test

bind ric_bank ric_bank_props ric_bank_props_inst (.clk(clk), .rstn(rstn), .rom_image(rom_image),
	.axi_req(axi_req), .axi_rsp(axi_rsp), .check_busy(check_busy), .check_bad(check_bad));
